// >>> design/dht_pkg.sv
`default_nettype none
package dht_pkg;
  // Register addresses on the four address inputs
  localparam logic [3:0] ADDR_DATA_PORT = 4'h0;  // Transmit/receive data port
  localparam logic [3:0] ADDR_DMA_SETUP = 4'h7;  // DMA setup register
  localparam logic [3:0] ADDR_FIFO_THR  = 4'h8;  // FIFO threshold control register
  // Values after reset
  localparam logic [7:0] DMA_SETUP_RST  = 8'h00; // DMA off, select 00
  localparam logic [7:0] FIFO_THR_RST   = 8'h77; // Both thresholds code 0111
  // Field positions
  localparam int DMA_EN_BIT  = 0;                // DMA mode enable
  localparam int DMA_SEL_LSB = 1;                // Interface select, two bits
  localparam int TX_THR_LSB  = 0;                // Transmit threshold, four bits
  localparam int RX_THR_LSB  = 4;                // Receive threshold, four bits
  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;
  // Width of the bundle of pin inputs that is synchronised
  localparam int PIN_W       = 16;
  // Interface select encodings
  typedef enum logic [1:0] {
    DHT_SEL_RDMEM   = 2'b00,  // Request low, acknowledge high, read strobe fills device
    DHT_SEL_WRMEM   = 2'b01,  // Request high, acknowledge low, write strobe fills device
    DHT_SEL_NOACK_L = 2'b10,  // Request low, acknowledge ignored
    DHT_SEL_NOACK_H = 2'b11   // Request high, acknowledge ignored
  } dht_sel_t;
endpackage : dht_pkg
`default_nettype wire

// >>> design/dht_thr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dht_thr_if;
  logic [3:0] tx_code;   // Transmit threshold code
  logic [3:0] rx_code;   // Receive threshold code
  logic [5:0] tx_level;  // Transmit FIFO free bytes
  logic [5:0] rx_level;  // Receive FIFO filled bytes
  logic       tx_hit;    // Transmit threshold reached
  logic       rx_hit;    // Receive threshold reached
  modport cfg (output tx_code, rx_code, tx_level, rx_level, input tx_hit, rx_hit);
  modport thr (input tx_code, rx_code, tx_level, rx_level, output tx_hit, rx_hit);
endinterface : dht_thr_if
`default_nettype wire

// >>> design/dht_thresh.sv
`timescale 1ns/10ps
`default_nettype none
module dht_thresh (
  // Threshold carrier
  dht_thr_if.thr th
);
  // ****************************************
  // Threshold decode
  // ****************************************
  // Code zero is one byte, every other code is twice its value
  function automatic logic [5:0] thr_bytes(input logic [3:0] code);
    logic [5:0] b;
    b = 6'h00;
    // RULE10 - base table
    // RULE13 - two byte steps
    if (code == 4'h0) begin
      b = 6'h01;
    end else begin
      b = {1'b0, code, 1'b0};
    end
    return b;
  endfunction

  // Compare levels against decoded thresholds
  always_comb begin
    // RULE14 - receive coded alike
    th.rx_hit = (th.rx_level >= thr_bytes(th.rx_code));
    // RULE15 - threshold reach compare
    th.tx_hit = (th.tx_level >= thr_bytes(th.tx_code));
  end
endmodule : dht_thresh
`default_nettype wire

// >>> design/dht_top.sv
// Behaviour
// RULE1 - Select 01: request high, acknowledge low
// RULE2 - Select 01: write fills, read drains
// RULE3 - Acknowledge forces data port address
// RULE4 - Select 10: request low, acknowledge ignored
// RULE5 - Select 11: request high, acknowledge ignored
// RULE6 - Thresholds drive interrupt and DMA requests
// RULE7 - Reset restores FIFO control register
// RULE8 - Transmit threshold in bits 0-3
// RULE9 - Transmit threshold resets to 0111
// RULE10 - Codes 0-5 give 1,2,4,6,8,10
// RULE11 - Enable off: no request, resets zero
// RULE12 - Select 00: request low, read fills
// RULE13 - Codes 6-15 step two, top 30
// RULE14 - Receive threshold bits 4-7, same coding
// RULE15 - Request when level reaches threshold
`timescale 1ns/10ps
`default_nettype none
module dht_top (
  // Clock and reset
  input  wire  logic       sys_clk,
  input  wire  logic       sys_rst,
  // Host bus pins
  input  wire  logic       cs_n,
  input  wire  logic       rd_n,
  input  wire  logic       wr_n,
  input  wire  logic [3:0] register_address_inputs,
  input  wire  logic [7:0] data_in,
  output logic       [7:0] data_out,
  output logic             data_oe,
  // DMA pins
  output logic             dma_request_pin,
  input  wire  logic       dma_acknowledge_pin,
  // FIFO side, same clock
  input  wire  logic       rx_mode,
  input  wire  logic [5:0] tx_free_level,
  input  wire  logic [5:0] rx_fill_level,
  input  wire  logic [7:0] rx_data,
  output logic             tx_push,
  output logic       [7:0] tx_data,
  output logic             rx_pop,
  // Threshold interrupt conditions
  output logic             tx_irq_cond,
  output logic             rx_irq_cond
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [dht_pkg::PIN_W-1:0] pin_raw;                     // Bundled pin inputs
  logic [dht_pkg::PIN_W-1:0] sync_r [dht_pkg::SYNC_STAGES]; // Synchroniser stages
  logic [dht_pkg::PIN_W-1:0] filt_r;                      // Agreed pin levels
  logic [7:0]       dma_setup_r;         // DMA setup register
  logic [7:0]       fifo_thr_r;          // FIFO threshold control register
  logic             f_cs_n;              // Filtered chip select
  logic             f_rd_n;              // Filtered read strobe
  logic             f_wr_n;              // Filtered write strobe
  logic             f_ack;               // Filtered acknowledge level
  logic [3:0]       f_addr;              // Filtered address
  logic [7:0]       f_data;              // Filtered data bus
  logic             dma_en;              // DMA mode enable
  dht_pkg::dht_sel_t sel;                // Interface select
  logic             ack_act;             // Acknowledge asserted and honoured
  logic             swap;                // Read strobe moves data into device
  logic             acc_sel;             // Device selected for this access
  logic [3:0]       acc_addr;            // Effective address
  logic             we_lvl;              // Data flows into the device
  logic             re_lvl;              // Data flows out of the device
  logic             we_d_r;              // Previous write level
  logic             req_cond;            // Request condition for current direction
  logic [7:0]       rd_mux;              // Read data selection
  dht_thr_if        thr ();              // Carrier to threshold decode

  // ****************************************
  // Pin synchronisers
  // ****************************************
  assign pin_raw = {data_in, register_address_inputs, dma_acknowledge_pin, wr_n, rd_n, cs_n};

  // Three stages; idle high for the active low strobes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < dht_pkg::SYNC_STAGES; i++) begin
        sync_r[i] <= 16'h0007;
      end
    end else begin
      sync_r[0] <= pin_raw;
      for (int i = 1; i < dht_pkg::SYNC_STAGES; i++) begin
        sync_r[i] <= sync_r[i-1];
      end
    end
  end

  // A bit changes only once stages two and three agree
  generate
    for (genvar b = 0; b < dht_pkg::PIN_W; b++) begin : g_filt
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          filt_r[b] <= (b < 3) ? 1'b1 : 1'b0;
        end else if (sync_r[1][b] == sync_r[2][b]) begin
          filt_r[b] <= sync_r[2][b];
        end
      end
    end
  endgenerate

  assign f_cs_n = filt_r[0];
  assign f_rd_n = filt_r[1];
  assign f_wr_n = filt_r[2];
  assign f_ack  = filt_r[3];
  assign f_addr = filt_r[7:4];
  assign f_data = filt_r[15:8];

  // ****************************************
  // Access decode
  // ****************************************
  assign dma_en = dma_setup_r[dht_pkg::DMA_EN_BIT];
  assign sel    = dht_pkg::dht_sel_t'(dma_setup_r[dht_pkg::DMA_SEL_LSB +: 2]);

  // Acknowledge polarity per select; upper selects ignore it
  always_comb begin
    case (sel)
      // RULE12 - acknowledge active high
      dht_pkg::DHT_SEL_RDMEM:   ack_act = dma_en & f_ack;
      // RULE1 - acknowledge active low
      dht_pkg::DHT_SEL_WRMEM:   ack_act = dma_en & ~f_ack;
      // RULE4 - acknowledge ignored
      dht_pkg::DHT_SEL_NOACK_L: ack_act = 1'b0;
      // RULE5 - acknowledge ignored
      dht_pkg::DHT_SEL_NOACK_H: ack_act = 1'b0;
      default:                  ack_act = 1'b0;
    endcase
  end

  // RULE2 - write strobe fills
  // RULE12 - read strobe fills
  assign swap     = ack_act & (sel == dht_pkg::DHT_SEL_RDMEM);
  assign acc_sel  = ~f_cs_n | ack_act;
  // RULE3 - force data port
  assign acc_addr = ack_act ? dht_pkg::ADDR_DATA_PORT : f_addr;
  assign we_lvl   = acc_sel & (swap ? ~f_rd_n : ~f_wr_n);
  assign re_lvl   = acc_sel & (swap ? ~f_wr_n : ~f_rd_n);

  // Previous write level for start detection
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      we_d_r <= 1'b0;
    end else begin
      we_d_r <= we_lvl;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Writes take effect once, at the start of the strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // RULE7 - reset restores
      // RULE9 - code 0111
      fifo_thr_r  <= dht_pkg::FIFO_THR_RST;
      // RULE11 - enable resets low
      dma_setup_r <= dht_pkg::DMA_SETUP_RST;
    end else if (we_lvl && !we_d_r) begin
      if (acc_addr == dht_pkg::ADDR_FIFO_THR) begin
        fifo_thr_r <= f_data;
      end else if (acc_addr == dht_pkg::ADDR_DMA_SETUP) begin
        // Unused bits are not stored
        dma_setup_r <= {5'h00, f_data[2:0]};
      end
    end
  end

  // Data port push toward the transmit FIFO
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_push <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      tx_push <= we_lvl && !we_d_r && (acc_addr == dht_pkg::ADDR_DATA_PORT);
      if (we_lvl && !we_d_r) begin
        tx_data <= f_data;
      end
    end
  end

  // Read data selection; unmapped addresses read zero
  always_comb begin
    case (acc_addr)
      dht_pkg::ADDR_DATA_PORT: rd_mux = rx_data;
      dht_pkg::ADDR_DMA_SETUP: rd_mux = dma_setup_r;
      dht_pkg::ADDR_FIFO_THR:  rd_mux = fifo_thr_r;
      default:                 rd_mux = 8'h00;
    endcase
  end

  // Bus drive follows the read level; the pop fires once at its start
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
      rx_pop   <= 1'b0;
    end else begin
      data_oe  <= re_lvl;
      rx_pop   <= re_lvl && !data_oe && (acc_addr == dht_pkg::ADDR_DATA_PORT);
      // Hold data after the first cycle so the popped byte stays visible
      if (re_lvl && !data_oe) begin
        data_out <= rd_mux;
      end
    end
  end

  // ****************************************
  // Thresholds and request
  // ****************************************
  // RULE8 - low nibble transmit
  assign thr.tx_code  = fifo_thr_r[dht_pkg::TX_THR_LSB +: 4];
  // RULE14 - high nibble receive
  assign thr.rx_code  = fifo_thr_r[dht_pkg::RX_THR_LSB +: 4];
  assign thr.tx_level = tx_free_level;
  assign thr.rx_level = rx_fill_level;

  dht_thresh u_thresh (
    .th (thr)
  );

  // RULE15 - direction picks condition
  assign req_cond = rx_mode ? thr.rx_hit : thr.tx_hit;

  // Interrupt conditions share the threshold decode
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_irq_cond <= 1'b0;
      rx_irq_cond <= 1'b0;
    end else begin
      // RULE6 - shared thresholds
      tx_irq_cond <= thr.tx_hit & ~rx_mode;
      rx_irq_cond <= thr.rx_hit & rx_mode;
    end
  end

  // Request pin; select bit zero sets active high
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dma_request_pin <= 1'b1;
    end else begin
      // RULE11 - gate on enable
      // RULE1 - high when 01
      // RULE4 - low when 10
      // RULE5 - high when 11
      // RULE12 - low when 00
      dma_request_pin <= (dma_en & req_cond) ~^ sel[0];
    end
  end
endmodule : dht_top
`default_nettype wire

// >>> dv/dht_dmac_model.sv
`timescale 1ns/10ps
`default_nettype none
module dht_dmac_model (
  // Grant and polarity in use
  input wire logic grant,
  input wire logic ack_low,
  // Acknowledge pin
  output logic     ack
);
  assign ack = grant ? !ack_low : ack_low;
endmodule // dht_dmac_model
`default_nettype wire

// >>> dv/dht_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module dht_top_assertions (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // Host pins
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       data_oe,
  // FIFO side
  input wire logic       rx_mode,
  input wire logic [5:0] tx_free_level,
  input wire logic [5:0] rx_fill_level,
  input wire logic [7:0] tx_data,
  input wire logic       tx_push,
  input wire logic       rx_pop,
  input wire logic       tx_irq_cond,
  input wire logic       rx_irq_cond,
  input wire logic       dma_request_pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Plain host read held past the filter
  sequence rd_held;
    (!rd_n && !cs_n && wr_n)[*8];
  endsequence
  // Reset seen at one edge; its effect is due at the next
  sequence rst_seen;
    sys_rst ##1 1'b1;
  endsequence
  push_one_cycle_a: assert property (tx_push |=> !tx_push) else $error("push too long");
  pop_one_cycle_a: assert property (rx_pop |=> !rx_pop) else $error("pop too long");
  pop_drives_bus_a: assert property (rx_pop |-> data_oe) else $error("pop without drive");
  push_data_a: assert property (tx_push |=> $stable(tx_data)) else $error("data moved");
  read_drive_a: assert property (rd_held |-> data_oe) else $error("read not driven");
  oe_cause_a: assert property ($rose(data_oe) |-> !$past(rd_n, 2) || !$past(wr_n, 2)) else $error("drive uncaused");
  // Reset leaves request idle and the bus free
  reset_idle_a: assert property (disable iff (1'b0) rst_seen |-> dma_request_pin && !data_oe && !tx_push)
    else $error("reset not idle");
  tx_cond_a: assert property (tx_irq_cond && !$past(sys_rst) |->
    !$past(rx_mode) && $past(tx_free_level) != 6'h00) else $error("tx cond wrong");
  rx_cond_a: assert property (rx_irq_cond && !$past(sys_rst) |->
    $past(rx_mode) && $past(rx_fill_level) != 6'h00) else $error("rx cond wrong");
endmodule // dht_top_assertions
bind dht_top dht_top_assertions dht_top_assertions_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(cs_n),
  .rd_n(rd_n), .wr_n(wr_n), .data_oe(data_oe), .rx_mode(rx_mode), .tx_free_level(tx_free_level),
  .rx_fill_level(rx_fill_level), .tx_data(tx_data), .tx_push(tx_push), .rx_pop(rx_pop),
  .tx_irq_cond(tx_irq_cond), .rx_irq_cond(rx_irq_cond), .dma_request_pin(dma_request_pin));
`default_nettype wire

// >>> dv/dht_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dht_top_tb_top;
  logic sys_clk = 0, sys_rst = 1, cs_n = 1, rd_n = 1, wr_n = 1, rx_mode = 0, grant = 0, ack_low = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] data_in = 8'h00, rx_data = 8'h00, q, d, data_out, tx_data;
  logic [5:0] tx_free_level = 6'h00, rx_fill_level = 6'h00;
  logic data_oe, dma_request_pin, ack, tx_push, rx_pop, tx_irq_cond, rx_irq_cond, p, o;
  int failures = 0, samples_checked = 0, seed = 30, i, k;
  dht_top dht_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .register_address_inputs(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .dma_request_pin(dma_request_pin), .dma_acknowledge_pin(ack), .rx_mode(rx_mode),
    .tx_free_level(tx_free_level), .rx_fill_level(rx_fill_level), .rx_data(rx_data), .tx_push(tx_push),
    .tx_data(tx_data), .rx_pop(rx_pop), .tx_irq_cond(tx_irq_cond), .rx_irq_cond(rx_irq_cond));
  dht_dmac_model dht_dmac_model_i (.grant(grant), .ack_low(ack_low), .ack(ack));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic stop_test;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Strobe held long past the filter; pulses and read data are gathered meanwhile
  task automatic acc(input bit w, input bit c, input logic [3:0] a, input logic [7:0] dv);
    q = 8'h00; p = 0; o = 0; cs_n = !c; addr = a; data_in = dv;
    tick(5);
    if (w) wr_n = 0; else rd_n = 0;
    repeat (8) begin
      tick(1);
      if (tx_push === 1'b1) p = 1;
      if (rx_pop === 1'b1) o = 1;
      if (data_oe === 1'b1) q = data_out;
    end
    wr_n = 1; rd_n = 1;
    tick(8);
  endtask
  function automatic logic [5:0] thr(input logic [3:0] c);
    return (c == 4'h0) ? 6'h01 : {1'b0, c, 1'b0};
  endfunction
  initial begin
    tick(20); sys_rst = 0; tick(2);
    acc(0, 1, 4'h8, 8'h00); chk(q, 8'h77);
    acc(0, 1, 4'h7, 8'h00); chk(q, 8'h00);
    acc(0, 1, 4'h3, 8'h00); chk(q, 8'h00);
    for (i = 0; i < 16; i++) begin
      k = $random(seed) & 15;
      acc(1, 1, 4'h8, {k[3:0], i[3:0]}); acc(0, 1, 4'h8, 8'h00); chk(q, {k[3:0], i[3:0]});
      rx_mode = 0; tx_free_level = thr(i[3:0]) - 6'h01; tick(2); chk(8'(tx_irq_cond), 8'h00);
      tx_free_level = thr(i[3:0]); tick(2); chk(8'(tx_irq_cond), 8'h01);
      rx_mode = 1; rx_fill_level = 6'($random(seed) & 31); tick(2);
      chk(8'(rx_irq_cond), 8'(rx_fill_level >= thr(k[3:0])));
    end
    rx_mode = 0; tx_free_level = 6'h20;
    for (i = 0; i < 4; i++) begin
      ack_low = (i == 1);
      acc(1, 1, 4'h7, {5'h1f, i[1:0], 1'b0}); chk(8'(dma_request_pin), 8'(!i[0]));
      acc(1, 1, 4'h7, {5'h1f, i[1:0], 1'b1}); acc(0, 1, 4'h7, 8'h00); chk(q, {5'h00, i[1:0], 1'b1});
      chk(8'(dma_request_pin), 8'(i[0]));
      tx_free_level = 6'h00; tick(2); chk(8'(dma_request_pin), 8'(!i[0]));
      tx_free_level = 6'h20;
      // Drop DMA before the acknowledge level moves, or the next setup write is steered to the data port
      acc(1, 1, 4'h7, 8'h00); chk(8'(dma_request_pin), 8'h01);
    end
    for (i = 0; i < 4; i++) begin
      ack_low = (i == 1); acc(1, 1, 4'h7, {5'h00, i[1:0], 1'b1}); grant = 1;
      d = 8'($random(seed)); rx_data = 8'($random(seed));
      acc(1, 0, 4'hb, d); chk({6'h00, p, o}, (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : 8'h00);
      chk((i == 1) ? tx_data : q, (i >= 2) ? 8'h00 : (i == 1) ? d : rx_data);
      acc(0, 0, 4'h5, ~d); chk({6'h00, p, o}, (i == 0) ? 8'h02 : (i == 1) ? 8'h01 : 8'h00);
      chk((i == 0) ? tx_data : q, (i >= 2) ? 8'h00 : (i == 0) ? ~d : rx_data);
      grant = 0;
      // Same hazard as above: leave DMA off before the next acknowledge level
      acc(1, 1, 4'h7, 8'h00); chk(8'(dma_request_pin), 8'h01);
    end
    acc(1, 1, 4'h8, 8'h12); acc(0, 1, 4'h8, 8'h00); chk(q, 8'h12);
    sys_rst = 1; tick(4); sys_rst = 0; tick(2);
    acc(0, 1, 4'h8, 8'h00); chk(q, 8'h77);
    stop_test;
  end
  // Hang guard well beyond the expected run
  initial begin
    tick(20000); failures++; stop_test;
  end
endmodule // dht_top_tb_top
`default_nettype wire
